// >>> tb/tb_wcmp_regs.sv
// self-checking bench for the window comparator register bank
`timescale 1ns/10ps
module tb_wcmp_regs;
    import wcmp_pkg::*;
    logic         clk_sys = 1'b0;
    logic         rst_n = 1'b0;
    logic         hsel;
    logic [31:0]  haddr;
    logic [1:0]   htrans;
    logic         hwrite;
    logic [2:0]   hsize;
    logic [31:0]  hwdata;
    logic         hreadyout;
    logic         hresp;
    logic [31:0]  hrdata;
    logic         irq;
    wcmp_sample_t sample_in = '0;
    int           miscompares = 0;
    int           checks = 0;
    logic [31:0]  rd;
    logic         ok;
    logic [7:0]   exp_rst [8] = '{8'hf0, 8'hff, 8'h00, 8'h00,
                                  8'hf0, 8'hff, 8'h00, 8'h00};

    always #25 clk_sys = ~clk_sys;

    wcmp_regs wcmp_regs_i (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .sample_in(sample_in), .irq(irq));

    wcmp_host wcmp_host_i (.clk_sys(clk_sys), .hready(hreadyout),
        .hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    task automatic finish_test();
        if (miscompares == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic bus_ok();
        if (ok !== 1'b1) begin
            miscompares++;
            finish_test();
        end
    endtask

    // upper data bits set on purpose; only the low byte may land
    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        wcmp_host_i.xfer(1'b1, idx, {24'hffffff, v}, rd, ok);
        bus_ok();
    endtask

    task automatic rdc(input string nm, input logic [7:0] idx,
                       input logic [7:0] exp);
        wcmp_host_i.xfer(1'b0, idx, 32'h0, rd, ok);
        bus_ok();
        chk(nm, {24'h0, exp}, rd);
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic send(input logic [2:0] ch, input logic [11:0] d);
        @(posedge clk_sys);
        sample_in <= '{valid: 1'b1, chan: ch, data: d};
        @(posedge clk_sys);
        sample_in <= '0;
    endtask

    task automatic chk_irq(input logic exp);
        repeat (3) @(posedge clk_sys);
        chk("irq", {31'h0, exp}, {31'h0, irq});
    endtask

    initial begin
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rdc("reset value", 8'h34 + 8'(i), exp_rst[i]);
        end
        rdc("status reset", IDX_STATUS, 8'h00);
        rdc("mask reset", IDX_MASK, 8'h00);
        for (int i = 0; i < 8; i++) begin
            wr(8'h34 + 8'(i), 8'h5a + 8'(i * 19));
            rdc("readback", 8'h34 + 8'(i), 8'h5a + 8'(i * 19));
        end
        wr(8'h50, 8'h77);
        rdc("unmapped", 8'h50, 8'h00);
        // high limit 0x805, hysteresis 8, run of three samples
        wr(IDX_CH5_HYST, 8'h51);
        wr(IDX_CH5_HIGH, 8'h80);
        wr(IDX_CH5_RUN, 8'h02);
        wr(IDX_CH5_LOW, 8'h00);
        wr(IDX_CH6_HYST, 8'hf0);
        wr(IDX_CH6_HIGH, 8'hff);
        wr(IDX_MASK, 8'h01);
        send(3'h5, 12'h806);
        send(3'h5, 12'h806);
        send(3'h5, 12'h805);
        send(3'h5, 12'h806);
        send(3'h5, 12'h806);
        rdc("run broken", IDX_STATUS, 8'h00);
        chk_irq(1'b0);
        send(3'h5, 12'h806);
        chk_irq(1'b1);
        rdc("run complete", IDX_STATUS, 8'h01);
        chk_irq(1'b0);
        send(3'h5, 12'h7fe);
        rdc("hysteresis hold", IDX_STATUS, 8'h01);
        send(3'h5, 12'h7fd);
        send(3'h5, 12'h7fe);
        rdc("hysteresis release", IDX_STATUS, 8'h00);
        // low limit 0x405 on channel 6, single sample qualifies
        wr(IDX_CH6_RUN, 8'h50);
        wr(IDX_CH6_LOW, 8'h40);
        send(3'h6, 12'h405);
        rdc("low at limit", IDX_STATUS, 8'h00);
        send(3'h6, 12'h404);
        chk_irq(1'b0);
        rdc("low event", IDX_STATUS, 8'h08);
        rdc("status cleared", IDX_STATUS, 8'h00);
        finish_test();
    end
endmodule

// >>> tb/wcmp_host.sv
// bus master model issuing single word transfers to the bank
`timescale 1ns/10ps
module wcmp_host (
    input  wire logic        clk_sys,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    initial begin
        {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
    end

    task automatic wait_ready(output logic ok);
        ok = 1'b0;
        for (int w = 0; w < 16 && !ok; w++) begin
            @(posedge clk_sys);
            ok = (hready === 1'b1);
        end
    endtask

    // released address and write data lines show inverted values so stale data never matches
    task automatic xfer(input logic wr, input logic [7:0] idx,
                        input logic [31:0] wd, output logic [31:0] rd,
                        output logic ok);
        rd = '0;
        @(posedge clk_sys);
        hsel   <= 1'b1;
        haddr  <= {22'h0, idx, 2'b00};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize  <= 3'h2;
        wait_ready(ok);
        if (!ok) return;
        hsel   <= 1'b0;
        htrans <= 2'b00;
        haddr  <= ~{22'h0, idx, 2'b00};
        hwdata <= wd;
        wait_ready(ok);
        rd = hrdata;
        hwdata <= ~wd;
    endtask
endmodule

// >>> verilog/wcmp_pkg.sv
// constants and carrier types for the window comparator register bank
package wcmp_pkg;

    // register indices; byte address on the bus is four times the index
    localparam logic [7:0] IDX_CH5_HYST = 8'h34;
    localparam logic [7:0] IDX_CH5_HIGH = 8'h35;
    localparam logic [7:0] IDX_CH5_RUN  = 8'h36;
    localparam logic [7:0] IDX_CH5_LOW  = 8'h37;
    localparam logic [7:0] IDX_CH6_HYST = 8'h38;
    localparam logic [7:0] IDX_CH6_HIGH = 8'h39;
    localparam logic [7:0] IDX_CH6_RUN  = 8'h3a;
    localparam logic [7:0] IDX_CH6_LOW  = 8'h3b;
    localparam logic [7:0] IDX_STATUS   = 8'h40;
    localparam logic [7:0] IDX_MASK     = 8'h41;

    // slot layout inside the per-channel group of four registers
    localparam int unsigned CFG_SLOTS   = 8;
    localparam int unsigned CH_STRIDE   = 4;
    localparam int unsigned SLOT_HYST   = 0;
    localparam int unsigned SLOT_HIGH   = 1;
    localparam int unsigned SLOT_RUN    = 2;
    localparam int unsigned SLOT_LOW    = 3;

    // field positions
    localparam int unsigned NIB_MSB     = 7;
    localparam int unsigned NIB_LSB     = 4;
    localparam int unsigned FLD_MSB     = 3;
    localparam int unsigned FLD_LSB     = 0;
    localparam int unsigned HYST_SHIFT  = 3;

    // reset values
    localparam logic [7:0] RST_HYST     = 8'hf0;
    localparam logic [7:0] RST_HIGH     = 8'hff;
    localparam logic [7:0] RST_RUN      = 8'h00;
    localparam logic [7:0] RST_LOW      = 8'h00;
    localparam logic [3:0] RST_STATUS   = 4'h0;
    localparam logic [3:0] RST_MASK     = 4'h0;
    localparam logic [7:0] CFG_RST [CFG_SLOTS] = '{
        RST_HYST, RST_HIGH, RST_RUN, RST_LOW,
        RST_HYST, RST_HIGH, RST_RUN, RST_LOW};

    // status bit of channel g: high event at 2g, low event at 2g+1
    localparam int unsigned CH_COUNT    = 2;
    localparam logic [2:0]  CH5_ID      = 3'h5;

    typedef struct packed {
        logic        valid;
        logic [2:0]  chan;
        logic [11:0] data;
    } wcmp_sample_t;

    typedef struct packed {
        logic [11:0] high;
        logic [11:0] low;
        logic [11:0] hyst;
        logic [3:0]  run;
    } wcmp_limits_t;

endpackage

// >>> verilog/wcmp_regs.sv
// window comparator register bank for channels 5 and 6, AHB-Lite slave
`timescale 1ns/10ps
module wcmp_regs (
    input  wire logic                  clk_sys,
    input  wire logic                  rst_n,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic [31:0]                hrdata,
    input  wire wcmp_pkg::wcmp_sample_t sample_in,
    output logic                       irq
);
    import wcmp_pkg::*;

    function automatic logic cfg_hit(input logic [7:0] idx);
        return (idx >= IDX_CH5_HYST) && (idx <= IDX_CH6_LOW);
    endfunction

    function automatic logic [2:0] cfg_slot(input logic [7:0] idx);
        logic [7:0] d;
        d = idx - IDX_CH5_HYST;
        return d[2:0];
    endfunction

    function automatic wcmp_limits_t limits(input logic [7:0] hy,
                                            input logic [7:0] hi,
                                            input logic [7:0] rn,
                                            input logic [7:0] lo);
        wcmp_limits_t l;
        l.high = {hi, hy[NIB_MSB:NIB_LSB]};
        l.low  = {lo, rn[NIB_MSB:NIB_LSB]};
        l.hyst = {5'h00, hy[FLD_MSB:FLD_LSB], 3'h0};
        l.run  = rn[FLD_MSB:FLD_LSB];
        return l;
    endfunction

    logic [7:0]  cfg_q [CFG_SLOTS];
    logic [3:0]  status_q;
    logic [3:0]  status_set;
    logic [3:0]  mask_q;
    logic        wr_q;
    logic [7:0]  wr_idx_q;
    logic [31:0] hrdata_q;
    logic        acc;
    logic        a_map;
    logic [7:0]  a_idx;
    logic        rd_status;
    logic [7:0]  rd_val;
    logic [3:0]  run_cnt_q [CH_COUNT];
    logic        tripped_q [CH_COUNT];

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // ---------------- bus slave ----------------
    // zero wait states, so the slave never stretches a transfer
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

    assign acc       = hsel && htrans[1] && hready;
    assign a_idx     = haddr[9:2];
    assign a_map     = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
    assign rd_status = acc && !hwrite && a_map && (a_idx == IDX_STATUS);

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            wr_q     <= 1'b0;
            wr_idx_q <= 8'h00;
        end else if (hready) begin
            wr_q     <= acc && hwrite && a_map;
            wr_idx_q <= a_idx;
        end
    end

    // a read right behind a write to the same register sees the new value
    always_comb begin
        rd_val = 8'h00;
        if (!a_map) begin
            rd_val = 8'h00;
        end else if (cfg_hit(a_idx)) begin
            if (wr_q && (wr_idx_q == a_idx)) begin
                rd_val = hwdata[7:0];
            end else begin
                rd_val = cfg_q[cfg_slot(a_idx)];
            end
        end else if (a_idx == IDX_STATUS) begin
            rd_val = {4'h0, status_q};
        end else if (a_idx == IDX_MASK) begin
            if (wr_q && (wr_idx_q == IDX_MASK)) begin
                rd_val = {4'h0, hwdata[3:0]};
            end else begin
                rd_val = {4'h0, mask_q};
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            hrdata_q <= 32'h00000000;
        end else if (acc && !hwrite) begin
            hrdata_q <= {24'h000000, rd_val};
        end
    end

    // ---------------- configuration registers ----------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            for (int i = 0; i < CFG_SLOTS; i++) begin
                cfg_q[i] <= CFG_RST[i];
            end
        end else if (wr_q && cfg_hit(wr_idx_q)) begin
            cfg_q[cfg_slot(wr_idx_q)] <= hwdata[7:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            mask_q <= RST_MASK;
        end else if (wr_q && (wr_idx_q == IDX_MASK)) begin
            mask_q <= hwdata[3:0];
        end
    end

    // ---------------- interrupt status ----------------
    // set beats the read-clear so an event in the read cycle survives
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            status_q <= RST_STATUS;
        end else begin
            status_q <= (status_q & ~{4{rd_status}}) | status_set;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((status_q & ~{4{rd_status}}) | status_set) & mask_q);
        end
    end

    // ---------------- per-channel comparators ----------------
    for (genvar g = 0; g < CH_COUNT; g++) begin : g_ch
        localparam logic [2:0]  CH_ID = CH5_ID + 3'(g);
        localparam int unsigned BASE  = g * CH_STRIDE;

        wcmp_limits_t lim;
        logic [11:0]  hi_eff;
        logic [11:0]  lo_eff;
        logic         take;
        logic         above;
        logic         below;
        logic         fire;

        assign lim  = limits(cfg_q[BASE + SLOT_HYST], cfg_q[BASE + SLOT_HIGH],
                             cfg_q[BASE + SLOT_RUN],  cfg_q[BASE + SLOT_LOW]);
        assign take = sample_in.valid && (sample_in.chan == CH_ID);

        // once tripped, the window narrows by the hysteresis; saturates at
        // the code range so a large value cannot wrap the limits around
        always_comb begin
            hi_eff = lim.high;
            lo_eff = lim.low;
            if (tripped_q[g]) begin
                hi_eff = (lim.high > lim.hyst) ? lim.high - lim.hyst
                                               : 12'h000;
                lo_eff = (lim.low < 12'hfff - lim.hyst) ? lim.low + lim.hyst
                                                        : 12'hfff;
            end
        end

        assign above = sample_in.data > hi_eff;
        assign below = sample_in.data < lo_eff;
        assign fire  = take && (above || below)
                       && (run_cnt_q[g] >= lim.run);

        assign status_set[2*g]   = fire && above;
        assign status_set[2*g+1] = fire && below && !above;

        always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
                run_cnt_q[g] <= 4'h0;
            end else if (take) begin
                if (!(above || below)) begin
                    run_cnt_q[g] <= 4'h0;
                end else if (run_cnt_q[g] < lim.run) begin
                    run_cnt_q[g] <= run_cnt_q[g] + 4'h1;
                end
            end
        end

        always_ff @(posedge clk_sys) begin
            if (!rst_n) begin
                tripped_q[g] <= 1'b0;
            end else if (fire) begin
                tripped_q[g] <= 1'b1;
            end else if (take && !(above || below)) begin
                tripped_q[g] <= 1'b0;
            end
        end

        a_high_byte_cmp: assert property (
            take && !tripped_q[g]
            && sample_in.data[11:4] > cfg_q[BASE + SLOT_HIGH] |-> above)
            else $error("sample above high byte not seen as above");

        a_high_nibble_cmp: assert property (
            take && !tripped_q[g] && sample_in.data == lim.high |-> !above)
            else $error("sample equal to high limit seen as above");

        a_low_nibble_cmp: assert property (
            take && !tripped_q[g] && sample_in.data == lim.low |-> !below)
            else $error("sample equal to low limit seen as below");

        a_low_byte_cmp: assert property (
            take && !tripped_q[g]
            && sample_in.data[11:4] < cfg_q[BASE + SLOT_LOW] |-> below)
            else $error("sample below low byte not seen as below");

        a_hyst_band: assert property (
            take && tripped_q[g] && lim.high > lim.hyst
            && sample_in.data == lim.high - lim.hyst + 12'h001 |-> above)
            else $error("hysteresis not applied to high limit");

        a_run_flag: assert property (
            (take && (above || below) && run_cnt_q[g] == lim.run
            |=> (status_q[2*g] || status_q[2*g+1]))
            and (fire |-> run_cnt_q[g] >= lim.run))
            else $error("event flag not set after n+1 samples");

        a_run_restart: assert property (
            take && !(above || below)
            |=> run_cnt_q[g] == 4'h0 && !tripped_q[g])
            else $error("run counter not restarted");

        c_event_fire: cover property (fire && lim.run > 4'h1);
    end

    a_ch5_decode: assert property (
        acc && hwrite && a_map && a_idx == IDX_CH5_RUN
        |=> ##1 cfg_q[SLOT_RUN] == $past(hwdata[7:0]))
        else $error("write to 0x36 did not reach channel 5 run register");

    a_ch6_decode: assert property (
        acc && hwrite && a_map && a_idx == IDX_CH6_LOW
        |=> ##1 cfg_q[CH_STRIDE + SLOT_LOW] == $past(hwdata[7:0]))
        else $error("write to 0x3b did not reach channel 6 low register");

    a_reset_vals: assert property (
        @(posedge clk_sys) disable iff (1'b0)
        !rst_n |=> cfg_q[SLOT_HIGH] == RST_HIGH
        && cfg_q[CH_STRIDE + SLOT_HYST] == RST_HYST
        && cfg_q[SLOT_LOW] == RST_LOW && cfg_q[CH_STRIDE + SLOT_RUN] == RST_RUN)
        else $error("configuration reset values wrong");

    c_status_read: cover property (rd_status && status_q != 4'h0);
    c_irq_rise:    cover property (!irq ##1 irq);
    c_back_to_back: cover property (wr_q && acc && !hwrite && a_idx == wr_idx_q);

endmodule
